// ==== common/irq_mode_params.svh ====
`ifndef IRQ_MODE_PARAMS_SVH
`define IRQ_MODE_PARAMS_SVH
// Register byte addresses (index times four)
`define IDX_IRQ_EN1 8'h05
`define IDX_IRQ_EN2 8'h06
`define IDX_MODE1 8'h07
`define IDX_STATUS1 8'h03
`define IDX_STATUS2 8'h04
`define ADDR_IRQ_EN1 12'h014
`define ADDR_IRQ_EN2 12'h018
`define ADDR_MODE1 12'h01C
`define ADDR_STATUS1 12'h00C
`define ADDR_STATUS2 12'h010
// Reset values
`define RST_IRQ_EN1 8'h00
`define RST_IRQ_EN2 8'h00
`define RST_MODE1 8'h00
// Writable bit masks, reserved positions are zero
`define MASK_IRQ_EN1 8'h9B
`define MASK_IRQ_EN2 8'hFF
`define MASK_MODE1 8'hF7
// Mode control bit positions
`define BIT_SWRES 7
`define BIT_LBD_EN 6
`define BIT_WUT_EN 5
`define BIT_LF_SEL 4
`define BIT_RX_ON 2
`define BIT_PLL_ON 1
`define BIT_XTAL_ON 0
// Status 2 bit positions
`define BIT_PREA_VAL 6
`define BIT_PREA_INV 5
`define BIT_LBD 2
`endif

// ==== common/irq_mode_pkg.sv ====
package irq_mode_pkg;
  // APB slave phase
  typedef enum logic [0:0] {APB_IDLE, APB_DONE} apb_state_t;
  typedef logic [7:0] reg8_t;
endpackage

// ==== rtl/irq_enable_and_mode_control.sv ====
// Functional notes
// - First enable register resets to zero
// - Enable bit 7 passes FIFO errors
// - Enable bit 4 passes FIFO almost-full
// - Enable bit 3 passes external interrupt
// - Enable bit 1 passes valid packet
// - Enable bit 0 passes CRC error
// - Second enable bit 7 gates sync word
// - Bit 6 gates valid preamble, needs detection
// - Bit 5 gates invalid preamble, needs detection
// - Bit 4 gates RSSI threshold event
// - Bit 3 gates wake-up timer expiry
// - Bit 2 gates low-battery event
// - Bit 1 gates crystal-ready event
// - Bit 0 gates power-on-reset event
// - Mode bit 7 resets registers, self-clears
// - Mode bit 6 runs low-battery detector
// - Mode bit 5 runs wake-up timer
// - Mode bit 4 selects RC or crystal
// - Mode bit 2 receiver on, auto-clears
// - Mode bit 1 keeps PLL on idle
// - Mode bit 0 keeps crystal running
// - Enabled rising status drives interrupt low
// - Status read releases pin, clears enabled
// - Low-battery latched even while disabled
`timescale 1ns/10ps
`default_nettype none
`include "irq_mode_params.svh"
module irq_enable_and_mode_control
(
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Event pulses, same clock domain
  input wire logic [7:0] events1,
  input wire logic [7:0] events2,
  input wire logic preamble_detect_en,
  input wire logic multi_packet_en,
  // Receiver controls
  output logic lbd_enable,
  output logic wut_enable,
  output logic low_freq_osc_select,
  output logic rx_on,
  output logic pll_on,
  output logic xtal_on,
  // Interrupt pin
  output logic interrupt_out_n
);
  // Enable and mode registers
  irq_mode_pkg::reg8_t en1_q;
  irq_mode_pkg::reg8_t en2_q;
  irq_mode_pkg::reg8_t mode_q;
  // Latched event status
  irq_mode_pkg::reg8_t st1_q;
  irq_mode_pkg::reg8_t st2_q;
  // Previous event levels for rise detection
  irq_mode_pkg::reg8_t ev1_prev_q;
  irq_mode_pkg::reg8_t ev2_prev_q;
  irq_mode_pkg::apb_state_t apb_q;
  logic soft_reset_q;
  logic wr_en;
  logic rd_en;
  irq_mode_pkg::reg8_t rise1;
  irq_mode_pkg::reg8_t rise2;
  irq_mode_pkg::reg8_t gate2;
  logic rd_st1;
  logic rd_st2;
  logic irq_d;

  // Address decode shared by read and write paths
  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a == r);
  endfunction

  // Writes land on the edge where the master sees pready high
  assign wr_en = psel && penable && pwrite && (apb_q == irq_mode_pkg::APB_DONE);
  // Reads capture and clear on the first access edge, so no event slips between
  assign rd_en = psel && penable && !pwrite && (apb_q == irq_mode_pkg::APB_IDLE);
  assign rd_st1 = rd_en && hit(paddr, `ADDR_STATUS1);
  assign rd_st2 = rd_en && hit(paddr, `ADDR_STATUS2);
  assign rise1 = events1 & ~ev1_prev_q;
  assign rise2 = events2 & ~ev2_prev_q;

  // Preamble enables only act with detection on
  always_comb
  begin
    gate2 = en2_q;
    if (!preamble_detect_en)
    begin
      gate2[`BIT_PREA_VAL] = 1'b0;
      gate2[`BIT_PREA_INV] = 1'b0;
    end
  end

  // Pin low while any enabled latched bit stands
  assign irq_d = |(st1_q & en1_q) || |(st2_q & gate2);

  // APB handshake, access phase with one wait state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      apb_q <= irq_mode_pkg::APB_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      // Ready registered, so answer comes one cycle into access
      if (psel && penable && apb_q == irq_mode_pkg::APB_IDLE)
      begin
        apb_q <= irq_mode_pkg::APB_DONE;
        pready <= 1'b1;
        pslverr <= !(hit(paddr, `ADDR_IRQ_EN1) || hit(paddr, `ADDR_IRQ_EN2) ||
                     hit(paddr, `ADDR_MODE1) || hit(paddr, `ADDR_STATUS1) ||
                     hit(paddr, `ADDR_STATUS2));
      end
      else
      begin
        apb_q <= irq_mode_pkg::APB_IDLE;
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // Read data, captured with the same decision as pready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd_en)
    begin
      if (hit(paddr, `ADDR_IRQ_EN1))
        prdata <= {24'h000000, en1_q};
      else if (hit(paddr, `ADDR_IRQ_EN2))
        prdata <= {24'h000000, en2_q};
      else if (hit(paddr, `ADDR_MODE1))
        prdata <= {24'h000000, mode_q};
      else if (hit(paddr, `ADDR_STATUS1))
        prdata <= {24'h000000, st1_q};
      else if (hit(paddr, `ADDR_STATUS2))
        prdata <= {24'h000000, st2_q};
      else
        prdata <= 32'h00000000;
    end
    else
      prdata <= 32'h00000000;
  end

  // Software reset pulse, one cycle after the write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      soft_reset_q <= 1'b0;
    else
      soft_reset_q <= wr_en && hit(paddr, `ADDR_MODE1) && pwdata[`BIT_SWRES];
  end

  // Enable registers; reserved positions masked
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en1_q <= `RST_IRQ_EN1;
      en2_q <= `RST_IRQ_EN2;
    end
    else if (soft_reset_q)
    begin
      en1_q <= `RST_IRQ_EN1;
      en2_q <= `RST_IRQ_EN2;
    end
    else if (wr_en)
    begin
      if (hit(paddr, `ADDR_IRQ_EN1))
        en1_q <= pwdata[7:0] & `MASK_IRQ_EN1;
      if (hit(paddr, `ADDR_IRQ_EN2))
        en2_q <= pwdata[7:0] & `MASK_IRQ_EN2;
    end
  end

  // Mode register; reset bit never stored, so it reads back cleared
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_q <= `RST_MODE1;
    else if (soft_reset_q)
      mode_q <= `RST_MODE1;
    else if (wr_en && hit(paddr, `ADDR_MODE1))
      mode_q <= pwdata[7:0] & `MASK_MODE1 & ~(8'h01 << `BIT_SWRES);
    else if (rise1[1] && !multi_packet_en)
      mode_q[`BIT_RX_ON] <= 1'b0;
  end

  // Event latches; a new rise wins over a read clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st1_q <= 8'h00;
      st2_q <= 8'h00;
      ev1_prev_q <= 8'h00;
      ev2_prev_q <= 8'h00;
    end
    else
    begin
      ev1_prev_q <= events1;
      ev2_prev_q <= events2;
      // Only enabled bits clear; disabled ones, e.g. low battery, persist
      st1_q <= (st1_q & ~(rd_st1 ? en1_q : 8'h00)) | (rise1 & `MASK_IRQ_EN1);
      st2_q <= (st2_q & ~(rd_st2 ? gate2 : 8'h00)) | rise2;
    end
  end

  // Registered active-low pin; released the cycle after a status read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      interrupt_out_n <= 1'b1;
    else
      interrupt_out_n <= !irq_d;
  end

  // Mode outputs straight from flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lbd_enable <= 1'b0;
      wut_enable <= 1'b0;
      low_freq_osc_select <= 1'b0;
      rx_on <= 1'b0;
      pll_on <= 1'b0;
      xtal_on <= 1'b0;
    end
    else
    begin
      lbd_enable <= mode_q[`BIT_LBD_EN];
      wut_enable <= mode_q[`BIT_WUT_EN];
      low_freq_osc_select <= mode_q[`BIT_LF_SEL];
      rx_on <= mode_q[`BIT_RX_ON];
      pll_on <= mode_q[`BIT_PLL_ON];
      xtal_on <= mode_q[`BIT_XTAL_ON];
    end
  end

  // Assertions
  property p_en1_reset_zero;
    @(posedge pclk) disable iff (!presetn) soft_reset_q |=> (en1_q == 8'h00);
  endproperty
  a_en1_reset_zero: assert property (p_en1_reset_zero) else $error("enable1 not cleared");

  property p_swres_clears;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && hit(paddr, `ADDR_MODE1) && pwdata[7]) |=> ##1 (mode_q == 8'h00 && en2_q == 8'h00);
  endproperty
  a_swres_clears: assert property (p_swres_clears) else $error("soft reset failed");

  property p_swres_selfclear;
    @(posedge pclk) disable iff (!presetn) mode_q[7] == 1'b0;
  endproperty
  a_swres_selfclear: assert property (p_swres_selfclear) else $error("reset bit stuck");

  sequence s_enabled_rise;
    (rise2[3] && en2_q[3]);
  endsequence
  property p_irq_on_event;
    @(posedge pclk) disable iff (!presetn) s_enabled_rise |=> ##1 !interrupt_out_n;
  endproperty
  a_irq_on_event: assert property (p_irq_on_event) else $error("irq missing");

  property p_lbd_latched;
    @(posedge pclk) disable iff (!presetn) rise2[2] |=> st2_q[2];
  endproperty
  a_lbd_latched: assert property (p_lbd_latched) else $error("lbd lost");

  property p_pre_gate;
    @(posedge pclk) disable iff (!presetn)
      (!preamble_detect_en && (st1_q & en1_q) == 8'h00 && (st2_q & en2_q & 8'h9F) == 8'h00)
      |=> interrupt_out_n;
  endproperty
  a_pre_gate: assert property (p_pre_gate) else $error("preamble not gated");

  property p_read_keeps_disabled;
    @(posedge pclk) disable iff (!presetn) (rd_st2 && st2_q[2] && !en2_q[2]) |=> st2_q[2];
  endproperty
  a_read_keeps_disabled: assert property (p_read_keeps_disabled) else $error("masked cleared");

  property p_rx_autoclear;
    @(posedge pclk) disable iff (!presetn)
      (rise1[1] && !multi_packet_en && !wr_en) |=> ##1 !rx_on;
  endproperty
  a_rx_autoclear: assert property (p_rx_autoclear) else $error("rx not cleared");

  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn) (en1_q[6:5] == 2'b00) && !en1_q[2] && !mode_q[3];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_lf_sel;
    @(posedge pclk) disable iff (!presetn) ##1 (low_freq_osc_select == $past(mode_q[4]));
  endproperty
  a_lf_sel: assert property (p_lf_sel) else $error("osc select wrong");

  // Detector enable output lags the mode bit by one edge
  property p_lbd_follow;
    @(posedge pclk) disable iff (!presetn) ##1 (lbd_enable == $past(mode_q[6]));
  endproperty
  a_lbd_follow: assert property (p_lbd_follow) else $error("detector enable wrong");

  // Wake timer enable output follows its mode bit
  property p_wut_follow;
    @(posedge pclk) disable iff (!presetn) ##1 (wut_enable == $past(mode_q[5]));
  endproperty
  a_wut_follow: assert property (p_wut_follow) else $error("wake timer enable wrong");

  // Receiver output follows its mode bit
  property p_rx_follow;
    @(posedge pclk) disable iff (!presetn) ##1 (rx_on == $past(mode_q[2]));
  endproperty
  a_rx_follow: assert property (p_rx_follow) else $error("receiver output wrong");

  // Tune output follows its mode bit
  property p_pll_follow;
    @(posedge pclk) disable iff (!presetn) ##1 (pll_on == $past(mode_q[1]));
  endproperty
  a_pll_follow: assert property (p_pll_follow) else $error("tune output wrong");

  // Ready output follows its mode bit
  property p_xtal_follow;
    @(posedge pclk) disable iff (!presetn) ##1 (xtal_on == $past(mode_q[0]));
  endproperty
  a_xtal_follow: assert property (p_xtal_follow) else $error("ready output wrong");

  // With multi-packet on, a valid packet leaves the receiver running
  property p_rx_multi_keep;
    @(posedge pclk) disable iff (!presetn)
      (rise1[1] && multi_packet_en && mode_q[2] && !wr_en && !soft_reset_q) |=> mode_q[2];
  endproperty
  a_rx_multi_keep: assert property (p_rx_multi_keep) else $error("receiver dropped");

  // Second enable register stores what was written
  property p_en2_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && hit(paddr, `ADDR_IRQ_EN2) && !soft_reset_q) |=> (en2_q == $past(pwdata[7:0]));
  endproperty
  a_en2_write: assert property (p_en2_write) else $error("enable2 write lost");

  // Nothing enabled pending, pin released next edge
  property p_idle_pin;
    @(posedge pclk) disable iff (!presetn)
      ((st1_q & en1_q) == 8'h00 && (st2_q & gate2) == 8'h00) |=> interrupt_out_n;
  endproperty
  a_idle_pin: assert property (p_idle_pin) else $error("pin low without cause");

  // Any enabled pending bit pulls the pin low next edge
  sequence s_enabled_pending;
    ((st1_q & en1_q) != 8'h00) || ((st2_q & gate2) != 8'h00);
  endsequence
  property p_pending_pin;
    @(posedge pclk) disable iff (!presetn) s_enabled_pending |=> !interrupt_out_n;
  endproperty
  a_pending_pin: assert property (p_pending_pin) else $error("pin high with cause");

  // Ready stands for a single cycle per transfer
  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn) pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

  // Error flag only ever rides along with ready
  property p_slverr_qual;
    @(posedge pclk) disable iff (!presetn) pslverr |-> pready;
  endproperty
  a_slverr_qual: assert property (p_slverr_qual) else $error("error without ready");
endmodule // irq_enable_and_mode_control
`default_nettype wire

// ==== test/apb_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module apb_host_model
(
  // Clock
  input wire logic pclk,
  // Request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  // Answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus from time zero
  initial
  begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // One transfer, held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e, output logic h);
    int n;
    begin
      n = 0;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      // Bounded wait, the slave picks its own latency
      do
      begin
        @(posedge pclk);
        n++;
      end
      while (pready !== 1'h1 && n < 16);
      // Answer taken at the same edge; a status read clears enabled bits
      q = prdata;
      e = pslverr;
      h = (pready !== 1'h1);
      psel <= 1'h0;
      penable <= 1'h0;
      // Idle edge so the next setup never lands in this time step
      @(posedge pclk);
    end
  endtask
endmodule // apb_host_model
`default_nettype wire

// ==== test/irq_enable_and_mode_control_test.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "irq_mode_params.svh"
module irq_enable_and_mode_control_test;
  // Table row: write, address, data, expected read, expected error
  typedef struct packed {logic w; logic [11:0] a; logic [7:0] d; logic [7:0] x; logic e;} row_t;
  row_t rows [11] = '{
    '{1'h0, `ADDR_IRQ_EN1, 8'h00, 8'h00, 1'h0},
    '{1'h0, `ADDR_IRQ_EN2, 8'h00, 8'h00, 1'h0},
    '{1'h0, `ADDR_MODE1, 8'h00, 8'h00, 1'h0},
    '{1'h1, `ADDR_IRQ_EN1, 8'hFF, 8'h00, 1'h0},
    '{1'h0, `ADDR_IRQ_EN1, 8'h00, 8'h9B, 1'h0},
    '{1'h1, `ADDR_IRQ_EN2, 8'hFF, 8'h00, 1'h0},
    '{1'h0, `ADDR_IRQ_EN2, 8'h00, 8'hFF, 1'h0},
    '{1'h1, `ADDR_MODE1, 8'h7F, 8'h00, 1'h0},
    '{1'h0, `ADDR_MODE1, 8'h00, 8'h77, 1'h0},
    '{1'h1, 12'h020, 8'h55, 8'h00, 1'h1},
    '{1'h0, 12'h020, 8'h00, 8'h00, 1'h1}};
  // Clock, reset and bus wires
  logic pclk = 1'h0;
  logic presetn;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  // Event and control wires
  logic [7:0] events1, events2, m;
  logic preamble_detect_en, multi_packet_en;
  logic lbd_enable, wut_enable, low_freq_osc_select, rx_on, pll_on, xtal_on, interrupt_out_n;
  int n_mismatch = 0;
  int total_checks = 0;
  // Free running clock, 4 ns period
  always #2 pclk = ~pclk;
  // Design under test
  irq_enable_and_mode_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .events1(events1), .events2(events2),
    .preamble_detect_en(preamble_detect_en), .multi_packet_en(multi_packet_en),
    .lbd_enable(lbd_enable), .wut_enable(wut_enable), .low_freq_osc_select(low_freq_osc_select),
    .rx_on(rx_on), .pll_on(pll_on), .xtal_on(xtal_on), .interrupt_out_n(interrupt_out_n));
  // Host side bus master
  apb_host_model u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // Verdict, single exit point
  task automatic results;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
    begin
      total_checks++;
      if (s !== x)
      begin
        $display("Error %s expected %h seen %h", nm, x, s);
        n_mismatch++;
      end
    end
  endtask
  // Register access; a hung bus ends the run
  task automatic rw(input logic w, input logic [11:0] a, input logic [7:0] d,
    input logic [7:0] x, input logic e = 1'h0);
    logic [31:0] q;
    logic se, h;
    begin
      u_host.xfer(w, a, {24'h0, d}, q, se, h);
      chk("bus_hang", 32'h0, {31'h0, h});
      if (h)
        results();
      chk("pslverr", {31'h0, e}, {31'h0, se});
      if (!w)
        chk("prdata", {24'h0, x}, q);
    end
  endtask
  // One-cycle event pulse
  task automatic pulse(input logic [7:0] a, input logic [7:0] b);
    begin
      events1 <= a;
      events2 <= b;
      @(posedge pclk);
      events1 <= 8'h00;
      events2 <= 8'h00;
      @(posedge pclk);
    end
  endtask
  // Bounded wait for the interrupt pin level
  task automatic wait_irq(input logic lv);
    int n;
    begin
      n = 0;
      while (interrupt_out_n !== lv && n < 8)
      begin
        @(posedge pclk);
        n++;
      end
      chk("interrupt_out_n", {31'h0, lv}, {31'h0, interrupt_out_n});
      if (interrupt_out_n !== lv)
        results();
    end
  endtask
  // Main sequence
  initial
  begin
    presetn = 1'h0;
    events1 = 8'h00;
    events2 = 8'h00;
    preamble_detect_en = 1'h1;
    multi_packet_en = 1'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    chk("interrupt_out_n", 32'h1, {31'h0, interrupt_out_n});
    chk("controls", 32'h0, {26'h0, lbd_enable, wut_enable, low_freq_osc_select, rx_on, pll_on, xtal_on});
    // Table of plain register accesses
    foreach (rows[i])
      rw(rows[i].w, rows[i].a, rows[i].d, rows[i].x, rows[i].e);
    chk("controls", 32'h3F, {26'h0, lbd_enable, wut_enable, low_freq_osc_select, rx_on, pll_on, xtal_on});
    // Every enabled source raises, then a status read releases
    for (int r = 0; r < 2; r++)
      for (int b = 0; b < 8; b++)
      begin
        m = r ? 8'hFF : 8'h9B;
        if (m[b])
        begin
          pulse(r ? 8'h00 : 8'h01 << b, r ? 8'h01 << b : 8'h00);
          wait_irq(1'h0);
          rw(1'h0, r ? `ADDR_STATUS2 : `ADDR_STATUS1, 8'h00, 8'h01 << b);
          wait_irq(1'h1);
        end
      end
    // Disabled events latch quietly and survive reads
    rw(1'h1, `ADDR_IRQ_EN2, 8'h00, 8'h00);
    pulse(8'h00, 8'h84);
    repeat (3) @(posedge pclk);
    chk("interrupt_out_n", 32'h1, {31'h0, interrupt_out_n});
    rw(1'h0, `ADDR_STATUS2, 8'h00, 8'h84);
    rw(1'h1, `ADDR_IRQ_EN2, 8'h04, 8'h00);
    wait_irq(1'h0);
    rw(1'h0, `ADDR_STATUS2, 8'h00, 8'h84);
    wait_irq(1'h1);
    rw(1'h0, `ADDR_STATUS2, 8'h00, 8'h80);
    // Preamble enables stay dormant with detection off
    rw(1'h1, `ADDR_IRQ_EN2, 8'hFF, 8'h00);
    rw(1'h0, `ADDR_STATUS2, 8'h00, 8'h80);
    wait_irq(1'h1);
    preamble_detect_en <= 1'h0;
    pulse(8'h00, 8'h60);
    repeat (3) @(posedge pclk);
    chk("interrupt_out_n", 32'h1, {31'h0, interrupt_out_n});
    rw(1'h0, `ADDR_STATUS2, 8'h00, 8'h60);
    preamble_detect_en <= 1'h1;
    wait_irq(1'h0);
    rw(1'h0, `ADDR_STATUS2, 8'h00, 8'h60);
    wait_irq(1'h1);
    // Receiver drops out after a valid packet
    rw(1'h1, `ADDR_MODE1, 8'h04, 8'h00);
    pulse(8'h02, 8'h00);
    rw(1'h0, `ADDR_MODE1, 8'h00, 8'h00);
    chk("rx_on", 32'h0, {31'h0, rx_on});
    // With multi-packet on the receiver stays on
    multi_packet_en <= 1'h1;
    rw(1'h1, `ADDR_MODE1, 8'h04, 8'h00);
    pulse(8'h02, 8'h00);
    rw(1'h0, `ADDR_MODE1, 8'h00, 8'h04);
    chk("rx_on", 32'h1, {31'h0, rx_on});
    multi_packet_en <= 1'h0;
    // Soft reset restores defaults and clears itself
    rw(1'h1, `ADDR_MODE1, 8'hC3, 8'h00);
    rw(1'h0, `ADDR_MODE1, 8'h00, 8'h00);
    rw(1'h0, `ADDR_IRQ_EN1, 8'h00, 8'h00);
    results();
  end
endmodule // irq_enable_and_mode_control_test
`default_nettype wire
